// >>> bridge_window_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module bridge_window_config_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [window_cfg_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [window_cfg_pkg::DATA_W-1:0] wdata,
  input wire logic [window_cfg_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [window_cfg_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [window_cfg_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic probe_valid,
  input wire logic [window_cfg_pkg::MEM_ADDR_W-1:0] probe_addr,
  input wire logic [window_cfg_pkg::IO_ADDR_W-1:0] probe_io_addr,
  output logic mem_hit,
  output logic prefetch_hit,
  output logic io_hit,
  output logic ext_mode
);
  import window_cfg_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [IDX_W:0] decode_idx(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[IDX_LSB-1:0] == '0) && (a[ADDR_W-1:IDX_MSB+1] == '0);
    return {ok, a[IDX_MSB:IDX_LSB]};
  endfunction : decode_idx

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    logic m;
    m = 1'b0;
    case (idx)
      IDX_MEM_BASE, IDX_MEM_LIMIT, IDX_PREF_BASE, IDX_PREF_LIMIT,
      IDX_PREF_BASE_UP, IDX_PREF_LIMIT_UP, IDX_IO_BASE_UP, IDX_IO_LIMIT_UP,
      IDX_CAP_PTR, IDX_EXP_ROM, IDX_INT_LINE, IDX_INT_PIN,
      IDX_MODE, IDX_STATUS: m = 1'b1;
      default: m = (idx >= IDX_RSVD_FIRST) && (idx <= IDX_RSVD_LAST);
    endcase
    return m;
  endfunction : is_mapped

  function automatic logic [DATA_W-1:0] merge_word(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [STRB_W-1:0] strb,
    input logic [DATA_W-1:0] mask
  );
    logic [DATA_W-1:0] lane;
    lane = '0;
    for (int i = 0; i < STRB_W; i++) begin
      lane[i*BYTE_W +: BYTE_W] = {BYTE_W{strb[i]}};
    end
    return (old & ~(lane & mask)) | (data & lane & mask);
  endfunction : merge_word

  // Base fills the granule with zeros, limit with ones
  function automatic logic [MEM_ADDR_W-1:0] win_addr(
    input logic [DATA_W-1:0] upper,
    input logic [DATA_W-1:0] lower,
    input logic top
  );
    logic [15:0] mid;
    mid = lower[15:0] & WIN_WR_MASK[15:0];
    if (top) begin
      return {upper, mid | GRAN_MID_ONES, GRAN_LOW_ONES};
    end
    return {upper, mid, GRAN_LOW_ZERO};
  endfunction : win_addr

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [DATA_W-1:0] mem_window_base_reg;
  logic [DATA_W-1:0] mem_window_limit_reg;
  logic [DATA_W-1:0] prefetch_window_base_reg;
  logic [DATA_W-1:0] prefetch_window_limit_reg;
  logic [DATA_W-1:0] prefetch_base_upper_reg;
  logic [DATA_W-1:0] prefetch_limit_upper_reg;
  logic [DATA_W-1:0] io_base_upper_reg;
  logic [DATA_W-1:0] io_limit_upper_reg;
  logic [DATA_W-1:0] interrupt_line_reg;
  logic [DATA_W-1:0] mode_reg;

  logic [DATA_W-1:0] up_mask;
  logic [DATA_W-1:0] io_dec_mask;

  assign ext_mode = (mode_reg[1:0] == EXTENDED_MODE_A) || (mode_reg[1:0] == EXTENDED_MODE_B);
  assign up_mask = ext_mode ? (UP_LO_MASK | UP_EXT_MASK) : UP_LO_MASK;
  assign io_dec_mask = ext_mode ? (IO_LO_MASK | IO_EXT_MASK) : IO_LO_MASK;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  wr_state_e wr_state_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [STRB_W-1:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic [IDX_W:0] wr_dec;
  logic [IDX_W-1:0] wr_idx;
  logic wr_do;
  logic wr_ok;

  assign awready = (wr_state_reg == WR_IDLE) && !aw_have_reg;
  assign wready = (wr_state_reg == WR_IDLE) && !w_have_reg;
  assign bvalid = (wr_state_reg == WR_RESP);
  assign bresp = bresp_reg;
  assign wr_dec = decode_idx(awaddr_reg);
  assign wr_idx = wr_dec[IDX_W-1:0];
  assign wr_ok = wr_dec[IDX_W] && is_mapped(wr_idx);
  assign wr_do = (wr_state_reg == WR_IDLE) && aw_have_reg && w_have_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= awaddr;
          end
          if (wvalid && wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
          end
          if (wr_do) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_DECERR;
            wr_state_reg <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state_reg <= WR_IDLE;
          end
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  function automatic logic hit_wr(input logic [IDX_W-1:0] idx);
    return wr_do && wr_ok && (wr_idx == idx);
  endfunction : hit_wr

  // ****************************************************************
  // Memory and prefetchable windows
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_window_base_reg <= WIN_RST;
      mem_window_limit_reg <= WIN_RST;
    end else begin
      if (hit_wr(IDX_MEM_BASE)) begin
        mem_window_base_reg <= merge_word(mem_window_base_reg, wdata_reg, wstrb_reg,
                                          WIN_WR_MASK);
      end
      if (hit_wr(IDX_MEM_LIMIT)) begin
        mem_window_limit_reg <= merge_word(mem_window_limit_reg, wdata_reg, wstrb_reg,
                                           WIN_WR_MASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prefetch_window_base_reg <= WIN_RST;
      prefetch_window_limit_reg <= WIN_RST;
      prefetch_base_upper_reg <= WIN_RST;
      prefetch_limit_upper_reg <= WIN_RST;
    end else begin
      if (hit_wr(IDX_PREF_BASE)) begin
        prefetch_window_base_reg <= merge_word(prefetch_window_base_reg, wdata_reg,
                                               wstrb_reg, WIN_WR_MASK);
      end
      if (hit_wr(IDX_PREF_LIMIT)) begin
        prefetch_window_limit_reg <= merge_word(prefetch_window_limit_reg, wdata_reg,
                                                wstrb_reg, WIN_WR_MASK);
      end
      if (hit_wr(IDX_PREF_BASE_UP)) begin
        prefetch_base_upper_reg <= merge_word(prefetch_base_upper_reg, wdata_reg,
                                              wstrb_reg, up_mask);
      end
      if (hit_wr(IDX_PREF_LIMIT_UP)) begin
        prefetch_limit_upper_reg <= merge_word(prefetch_limit_upper_reg, wdata_reg,
                                               wstrb_reg, up_mask);
      end
    end
  end

  // ****************************************************************
  // I/O window, interrupt line and mode
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_base_upper_reg <= WIN_RST;
      io_limit_upper_reg <= WIN_RST;
    end else begin
      if (hit_wr(IDX_IO_BASE_UP)) begin
        io_base_upper_reg <= merge_word(io_base_upper_reg, wdata_reg, wstrb_reg,
                                        IO_LO_MASK | IO_EXT_MASK);
      end
      if (hit_wr(IDX_IO_LIMIT_UP)) begin
        io_limit_upper_reg <= merge_word(io_limit_upper_reg, wdata_reg, wstrb_reg,
                                         IO_LO_MASK | IO_EXT_MASK);
      end
    end
  end

  // Interrupt line is scratch storage only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_line_reg <= INT_LINE_RST;
      mode_reg <= ZERO_WORD;
    end else begin
      if (hit_wr(IDX_INT_LINE)) begin
        interrupt_line_reg <= merge_word(interrupt_line_reg, wdata_reg, wstrb_reg,
                                         INT_LINE_MASK);
      end
      if (hit_wr(IDX_MODE)) begin
        mode_reg <= merge_word(mode_reg, wdata_reg, wstrb_reg, MODE_MASK);
      end
    end
  end

  // ****************************************************************
  // Window decode
  // ****************************************************************
  logic [MEM_ADDR_W-1:0] pref_up_base;
  logic [MEM_ADDR_W-1:0] pref_up_limit;
  logic [IO_ADDR_W-1:0] io_base;
  logic [IO_ADDR_W-1:0] io_limit;

  assign pref_up_base = win_addr(prefetch_base_upper_reg & up_mask, prefetch_window_base_reg,
                                 1'b0);
  assign pref_up_limit = win_addr(prefetch_limit_upper_reg & up_mask,
                                  prefetch_window_limit_reg, 1'b1);
  // Legacy decode forces I/O bits 31:25 to zero on both bounds
  assign io_base = {io_base_upper_reg[15:0] & io_dec_mask[15:0], GRAN_LOW_ZERO};
  assign io_limit = {io_limit_upper_reg[15:0] & io_dec_mask[15:0], GRAN_LOW_ONES};

  window_match #(.WIDTH(MEM_ADDR_W)) mem_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .probe_valid(probe_valid),
    .addr(probe_addr),
    .base(win_addr(ZERO_WORD, mem_window_base_reg, 1'b0)),
    .limit(win_addr(ZERO_WORD, mem_window_limit_reg, 1'b1)),
    .hit(mem_hit)
  );

  window_match #(.WIDTH(MEM_ADDR_W)) pref_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .probe_valid(probe_valid),
    .addr(probe_addr),
    .base(pref_up_base),
    .limit(pref_up_limit),
    .hit(prefetch_hit)
  );

  window_match #(.WIDTH(IO_ADDR_W)) io_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .probe_valid(probe_valid),
    .addr(probe_io_addr),
    .base(io_base),
    .limit(io_limit),
    .hit(io_hit)
  );

  // ****************************************************************
  // Read channel
  // ****************************************************************
  rd_state_e rd_state_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [IDX_W-1:0] rd_idx_reg;
  logic [IDX_W:0] rd_dec;

  assign arready = (rd_state_reg == RD_IDLE);
  assign rvalid = (rd_state_reg == RD_DATA);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign rd_dec = decode_idx(araddr);

  always_comb begin
    rdata_next = ZERO_WORD;
    case (rd_dec[IDX_W-1:0])
      IDX_MEM_BASE: rdata_next = mem_window_base_reg | MEM_ADDR_CAP;
      IDX_MEM_LIMIT: rdata_next = mem_window_limit_reg | MEM_ADDR_CAP;
      IDX_PREF_BASE: rdata_next = prefetch_window_base_reg | PREF_ADDR_CAP;
      IDX_PREF_LIMIT: rdata_next = prefetch_window_limit_reg | PREF_ADDR_CAP;
      IDX_PREF_BASE_UP: rdata_next = prefetch_base_upper_reg & up_mask;
      IDX_PREF_LIMIT_UP: rdata_next = prefetch_limit_upper_reg & up_mask;
      IDX_IO_BASE_UP: rdata_next = io_base_upper_reg;
      IDX_IO_LIMIT_UP: rdata_next = io_limit_upper_reg;
      IDX_CAP_PTR: rdata_next = CAP_PTR_VAL;
      IDX_EXP_ROM: rdata_next = EXP_ROM_VAL;
      IDX_INT_LINE: rdata_next = interrupt_line_reg;
      IDX_INT_PIN: rdata_next = INT_PIN_VAL;
      IDX_MODE: rdata_next = mode_reg;
      IDX_STATUS: begin
        rdata_next[STAT_MEM_HIT] = mem_hit;
        rdata_next[STAT_PREF_HIT] = prefetch_hit;
        rdata_next[STAT_IO_HIT] = io_hit;
        rdata_next[STAT_EXT] = ext_mode;
      end
      default: rdata_next = ZERO_WORD;
    endcase
    if (!rd_dec[IDX_W]) begin
      rdata_next = ZERO_WORD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= ZERO_WORD;
      rresp_reg <= RESP_OKAY;
      rd_idx_reg <= '0;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (arvalid) begin
            rdata_reg <= rdata_next;
            rresp_reg <= (rd_dec[IDX_W] && is_mapped(rd_dec[IDX_W-1:0])) ? RESP_OKAY
                                                                          : RESP_DECERR;
            rd_idx_reg <= rd_dec[IDX_W-1:0];
            rd_state_reg <= RD_DATA;
          end
        end
        RD_DATA: begin
          if (rready) begin
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_mem_base_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_wr(IDX_MEM_BASE) && wstrb_reg == STRB_ALL)
    |=> mem_window_base_reg == ($past(wdata_reg) & WIN_WR_MASK))
    else $error("memory base did not take written address bits");

  a_mem_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && (rd_idx_reg == IDX_MEM_BASE || rd_idx_reg == IDX_MEM_LIMIT))
    |-> rdata[3:0] == 4'h0)
    else $error("memory window low bits not zero");

  a_pref_low_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && (rd_idx_reg == IDX_PREF_BASE || rd_idx_reg == IDX_PREF_LIMIT))
    |-> rdata[3:0] == 4'h1)
    else $error("prefetchable low bits not one");

  a_upper_legacy: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !ext_mode && $stable(ext_mode)
     && (rd_idx_reg == IDX_PREF_BASE_UP || rd_idx_reg == IDX_PREF_LIMIT_UP))
    |-> rdata[31:8] == 24'h000000)
    else $error("upper bits readable in legacy mode");

  a_upper_byte_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_wr(IDX_PREF_BASE_UP) && wstrb_reg[0])
    |=> prefetch_base_upper_reg[7:0] == $past(wdata_reg[7:0]))
    else $error("upper base byte not written");

  a_io_upper_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_wr(IDX_IO_LIMIT_UP) && wstrb_reg == STRB_ALL)
    |=> io_limit_upper_reg[8:0] == $past(wdata_reg[8:0]))
    else $error("I/O limit upper bits not written");

  a_cap_pointer: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && rd_dec[IDX_W] && rd_dec[IDX_W-1:0] == IDX_CAP_PTR)
    |=> rvalid && rdata == 32'h00000040 && rresp == RESP_OKAY)
    else $error("capability pointer not 40h");

  a_warm_reset: assert property (@(posedge aclk)
    !aresetn |=> (mem_window_base_reg == '0 && prefetch_limit_upper_reg == '0
                  && io_base_upper_reg == '0 && interrupt_line_reg == 32'h000000FF))
    else $error("field kept value through warm reset");

endmodule : bridge_window_config_regs
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import window_cfg_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] rst; logic [31:0] wr; logic [31:0] exp;} row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, probe_valid;
  logic awready, wready, bvalid, arready, rvalid, mem_hit, prefetch_hit, io_hit, ext_mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d, probe_io_addr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [63:0] probe_addr;
  int mismatches, n_compared, m;
  row_s rows [13] = '{
    '{12'h080, 32'h0, 32'hFFFFFFFF, 32'h0000FFF0}, '{12'h088, 32'h0, 32'hFFFFFFFF, 32'h0000FFF0},
    '{12'h090, 32'h1, 32'hFFFFFFFF, 32'h0000FFF1}, '{12'h098, 32'h1, 32'hFFFFFFFF, 32'h0000FFF1},
    '{12'h0A0, 32'h0, 32'hFFFFFFFF, 32'h000000FF}, '{12'h0B0, 32'h0, 32'hFFFFFFFF, 32'h000000FF},
    '{12'h0C0, 32'h0, 32'hFFFFFFFF, 32'h0000FFFF}, '{12'h0C8, 32'h0, 32'hFFFFFFFF, 32'h0000FFFF},
    '{12'h0D0, 32'h40, 32'hFFFFFFFF, 32'h40}, '{12'h0D4, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{12'h0E0, 32'h0, 32'hFFFFFFFF, 32'h0}, '{12'h0F0, 32'hFF, 32'h5A, 32'h5A},
    '{12'h0F4, 32'h0, 32'hFFFFFFFF, 32'h0}};
  logic [63:0] pm [7] = '{64'h100000, 64'hFFFFF, 64'h2FFFFF, 64'h300000,
    64'hFF_FFF00000, 64'hFF_FFFFFFFF, 64'h100_00000000};
  logic [31:0] pi [7] = '{32'h10000, 32'hFFFF, 32'h2FFFF, 32'h30000, 32'h0, 32'h0, 32'h0};
  logic [2:0] pe [7] = '{3'h5, 3'h0, 3'h5, 3'h0, 3'h2, 3'h2, 3'h0};

  bridge_window_config_regs u_bridge_window_config_regs (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .probe_valid, .probe_addr, .probe_io_addr,
    .mem_hit, .prefetch_hit, .io_hit, .ext_mode);

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic complete_run;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 100) begin
      mismatches++;
      $display("unexpected at %0t: no answer", $time);
      complete_run();
    end
  endtask : tmo

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    rsp = bresp;
    tmo(n);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd_d = rdata;
    rsp = rresp;
    tmo(n);
  endtask : rd

  // Probe is taken at the next edge, flags are sampled at the edge after it
  task automatic pr(input logic [63:0] ma, input logic [31:0] ia, input logic [2:0] e);
    probe_addr <= ma;
    probe_io_addr <= ia;
    probe_valid <= 1'h1;
    @(posedge aclk);
    probe_valid <= 1'h0;
    @(posedge aclk);
    chk({mem_hit, prefetch_hit, io_hit}, e);
  endtask : pr

  task automatic chk_rst;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(rd_d, rows[i].rst);
    end
  endtask : chk_rst

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, probe_valid} = 5'h0;
    {bready, rready, wstrb} = 6'h3F;
    {awaddr, araddr, wdata, probe_addr, probe_io_addr} = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk_rst();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wr);
      chk(rsp, RESP_OKAY);
      rd(rows[i].a);
      chk(rd_d, rows[i].exp);
    end
    wr(12'h080, 32'h10);
    wr(12'h088, 32'h20);
    wr(12'h0C0, 32'h1);
    wr(12'h0C8, 32'h2);
    wr(12'h081, 32'hFFFF);
    chk(rsp, RESP_DECERR);
    wr(12'h3FC, 32'h0);
    chk(rsp, RESP_DECERR);
    rd(12'h082);
    chk({rsp, rd_d}, {RESP_DECERR, ZERO_WORD});
    rd(12'h080);
    chk(rd_d, 32'h10);
    foreach (pm[i]) pr(pm[i], pi[i], pe[i]);
    @(posedge aclk);
    chk({mem_hit, prefetch_hit, io_hit}, 3'h0);
    // Status word captures the flags of the probe one cycle before the read
    probe_addr <= 64'h100000;
    probe_io_addr <= 32'h10000;
    probe_valid <= 1'h1;
    @(posedge aclk);
    probe_valid <= 1'h0;
    rd(12'h144);
    chk(rd_d, 32'h5);
    // Bit 9 of the I/O base counts only in the extended modes
    wr(12'h0C0, 32'h201);
    // Mode code 3 behaves as legacy
    for (int i = 1; i < 5; i++) begin
      m = i % 4;
      wr(12'h140, m);
      chk(ext_mode, m == 1 || m == 2);
      wr(12'h0A0, 32'hFFFFFFFF);
      rd(12'h0A0);
      chk(rd_d, (m == 1 || m == 2) ? 32'hFFFFFFFF : 32'hFF);
      pr(64'h0, 32'h10000, {2'h0, m == 0 || m == 3});
    end
    // Only the enabled byte lane is written
    wstrb <= 4'h2;
    wr(12'h0C8, 32'h0000AB00);
    wstrb <= 4'hF;
    rd(12'h0C8);
    chk(rd_d, 32'h0000AB02);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk_rst();
    chk(ext_mode, 1'h0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// >>> window_cfg_pkg.sv

// ****************************************************************
// Constants of the bridge window register bank
// ****************************************************************
package window_cfg_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int MEM_ADDR_W = 64;
  localparam int IO_ADDR_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MEM_BASE = 8'h20;
  localparam logic [IDX_W-1:0] IDX_MEM_LIMIT = 8'h22;
  localparam logic [IDX_W-1:0] IDX_PREF_BASE = 8'h24;
  localparam logic [IDX_W-1:0] IDX_PREF_LIMIT = 8'h26;
  localparam logic [IDX_W-1:0] IDX_PREF_BASE_UP = 8'h28;
  localparam logic [IDX_W-1:0] IDX_PREF_LIMIT_UP = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_IO_BASE_UP = 8'h30;
  localparam logic [IDX_W-1:0] IDX_IO_LIMIT_UP = 8'h32;
  localparam logic [IDX_W-1:0] IDX_CAP_PTR = 8'h34;
  localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 8'h35;
  localparam logic [IDX_W-1:0] IDX_RSVD_LAST = 8'h37;
  localparam logic [IDX_W-1:0] IDX_EXP_ROM = 8'h38;
  localparam logic [IDX_W-1:0] IDX_INT_LINE = 8'h3C;
  localparam logic [IDX_W-1:0] IDX_INT_PIN = 8'h3D;
  localparam logic [IDX_W-1:0] IDX_MODE = 8'h50;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h51;

  // Writable field masks
  localparam logic [DATA_W-1:0] WIN_WR_MASK = 32'h0000FFF0;
  localparam logic [DATA_W-1:0] UP_LO_MASK = 32'h000000FF;
  localparam logic [DATA_W-1:0] UP_EXT_MASK = 32'hFFFFFF00;
  localparam logic [DATA_W-1:0] IO_LO_MASK = 32'h000001FF;
  localparam logic [DATA_W-1:0] IO_EXT_MASK = 32'h0000FE00;
  localparam logic [DATA_W-1:0] INT_LINE_MASK = 32'h000000FF;
  localparam logic [DATA_W-1:0] MODE_MASK = 32'h00000003;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

  // Read-only values and reset values
  localparam logic [DATA_W-1:0] MEM_ADDR_CAP = 32'h00000000;
  localparam logic [DATA_W-1:0] PREF_ADDR_CAP = 32'h00000001;
  localparam logic [DATA_W-1:0] CAP_PTR_VAL = 32'h00000040;
  localparam logic [DATA_W-1:0] EXP_ROM_VAL = 32'h00000000;
  localparam logic [DATA_W-1:0] INT_PIN_VAL = 32'h00000000;
  localparam logic [DATA_W-1:0] WIN_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] INT_LINE_RST = 32'h000000FF;
  localparam logic [STRB_W-1:0] STRB_ALL = 4'hF;

  // Window granule fill for assembled addresses
  localparam logic [15:0] GRAN_LOW_ZERO = 16'h0000;
  localparam logic [15:0] GRAN_LOW_ONES = 16'hFFFF;
  localparam logic [15:0] GRAN_MID_ONES = 16'h000F;

  localparam int STAT_MEM_HIT = 0;
  localparam int STAT_PREF_HIT = 1;
  localparam int STAT_IO_HIT = 2;
  localparam int STAT_EXT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    LEGACY_MODE_A = 2'h0,
    EXTENDED_MODE_A = 2'h1,
    EXTENDED_MODE_B = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;

endpackage : window_cfg_pkg

// >>> window_match.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Registered inclusive window compare
// ****************************************************************
module window_match #(
  parameter int WIDTH = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic probe_valid,
  input wire logic [WIDTH-1:0] addr,
  input wire logic [WIDTH-1:0] base,
  input wire logic [WIDTH-1:0] limit,
  output logic hit
);
  import window_cfg_pkg::*;

  logic hit_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= probe_valid && (addr >= base) && (addr <= limit);
    end
  end

  assign hit = hit_reg;

  a_hit_inside: assert property (@(posedge aclk) disable iff (!aresetn)
    hit |-> $past(probe_valid) && ($past(addr) >= $past(base)) && ($past(addr) <= $past(limit)))
    else $error("window hit outside base and limit");

  a_miss_inside: assert property (@(posedge aclk) disable iff (!aresetn)
    (probe_valid && addr >= base && addr <= limit) |=> hit)
    else $error("window miss inside base and limit");

endmodule : window_match
`default_nettype wire
